// ### include/epw_pkg.sv
/*
  epw_pkg: register map, field positions, reset values and mode codes
  for the enhanced PWM output stage.
  assumes an APB slave with 32-bit data, one register per aligned word.
*/
package epw_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] EPW_OFF_TIMER_SEL = 8'h00;
  localparam logic [7:0] EPW_OFF_MODE_CTRL = 8'h04;
  localparam logic [7:0] EPW_OFF_SHUTDOWN  = 8'h08;
  localparam logic [7:0] EPW_OFF_STEERING  = 8'h0c;
  localparam logic [7:0] EPW_OFF_DEADBAND  = 8'h10;
  localparam logic [7:0] EPW_OFF_DUTY_HIGH = 8'h14;
  localparam logic [7:0] EPW_OFF_STATUS    = 8'h18;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] EPW_RST_TIMER_SEL = 8'h00;
  localparam logic [7:0] EPW_RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] EPW_RST_SHUTDOWN  = 8'h00;
  localparam logic [7:0] EPW_RST_STEERING  = 8'h01;
  localparam logic [7:0] EPW_RST_DEADBAND  = 8'h00;
  localparam logic [7:0] EPW_RST_DUTY_HIGH = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int EPW_CFG_POS     = 6;
  localparam int EPW_DLOW_POS    = 4;
  localparam int EPW_ASE_POS     = 7;
  localparam int EPW_PSS_AC_POS  = 2;
  localparam int EPW_PSS_BD_POS  = 0;
  localparam int EPW_SYNC_POS    = 4;
  localparam int EPW_RSEN_POS    = 7;

  // ****************************************
  // mode and configuration codes
  // ****************************************
  localparam logic [3:0] EPW_MODE_OFF      = 4'h0;
  localparam logic [3:0] EPW_MODE_CMP_TGL  = 4'h2;
  localparam logic [3:0] EPW_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] EPW_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] EPW_MODE_CAP_R4   = 4'h6;
  localparam logic [3:0] EPW_MODE_CAP_R16  = 4'h7;
  localparam logic [3:0] EPW_MODE_CMP_SET  = 4'h8;
  localparam logic [3:0] EPW_MODE_CMP_CLR  = 4'h9;
  localparam logic [3:0] EPW_MODE_CMP_SW   = 4'ha;
  localparam logic [3:0] EPW_MODE_CMP_SPEC = 4'hb;
  localparam logic [1:0] EPW_PWM_TOP       = 2'h3;
  localparam logic [1:0] EPW_CFG_SINGLE    = 2'h0;
  localparam logic [1:0] EPW_CFG_FWD       = 2'h1;
  localparam logic [1:0] EPW_CFG_HALF      = 2'h2;
  localparam logic [1:0] EPW_CFG_REV       = 2'h3;
  localparam logic [1:0] EPW_PSS_LOW       = 2'h0;
  localparam logic [1:0] EPW_PSS_HIGH      = 2'h1;

  // ****************************************
  // timing
  // ****************************************
  localparam int         EPW_TOSC_PER_CYC  = 4;
  localparam logic [7:0] EPW_DIR_LEAD      = 8'h04;
  localparam logic [3:0] EPW_CAP_DIV4      = 4'h3;
  localparam logic [3:0] EPW_CAP_DIV16     = 4'hf;

  typedef enum logic [1:0] {
    EPW_DIR_RUN  = 2'b00,
    EPW_DIR_TURN = 2'b01,
    EPW_DIR_WAIT = 2'b11
  } epw_dir_t;

endpackage

// ### core/epw_output_stage.sv
/*
  epw_output_stage: enhanced capture/compare/PWM output stage with APB
  register access, pin steering, dead-band, polarity and auto-shutdown.
  assumes timer count/period/match come from outside, synchronous to clk_sys,
  and that one clk_sys cycle is one instruction cycle.
*/
// Chosen here: the APB interface to the registers and the register offsets.
// Operation
// - dead-band only on inactive-to-active edge
// - seven-bit count sets dead-band instruction cycles
// - single mode copies PWM to steered pins
// - low mode bits set steered pin polarity
// - shutdown forces only PWM-enabled pins
// - sync off: steering applies immediately
// - sync on: steering waits next period
// - timer flag set as second period begins
// - config selects forward, half or reverse bridge
// - outside PWM, A is capture/compare pin
// - duty low bits extend duty to ten
// - mode 0000 turns off and resets
// - capture falling, rising, 4th, 16th rising
// - compare toggle, set, clear, flag-only modes
// - special event resets timer, flags, starts conversion
// - pair polarities set independently, 1 active-low
// - output config absent on simple modules
// - dead-band above duty keeps output inactive
// - direction change four counts before period end
// - shutdown state field drives low, high, float
`timescale 1ns/1ps
module epw_output_stage
  import epw_pkg::*;
#(
  parameter bit HAS_BRIDGE    = 1'b1,
  parameter bit IS_SECOND_MOD = 1'b0
) (
  // clock, reset, enable
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              clk_en,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // timer interface
  input  wire logic [7:0]        tmr_count,
  input  wire logic [7:0]        tmr_period,
  input  wire logic [1:0]        tmr_prescale,
  input  wire logic              tmr_period_match,
  input  wire logic              cmp_match,
  input  wire logic              capture_pin,
  input  wire logic              shutdown_in,
  // events
  output logic                   timer_period_flag,
  output logic                   module_event_flag,
  output logic                   capture_strobe,
  output logic                   timer_reset,
  output logic                   adc_start,
  // pins
  output logic [3:0]             pin_out,
  output logic [3:0]             pin_oe,
  output logic [3:0]             pin_owned
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] tsel;
    logic [7:0] mode;
    logic [7:0] sdc;
    logic [7:0] steer;
    logic [3:0] steer_act;
    logic [7:0] dbc;
    logic [7:0] duty;
    logic [9:0] duty_lat;
    logic [1:0] cfg_act;
    epw_dir_t   dir;
    logic       pwm_raw;
    logic       out_a;
    logic       out_b;
    logic [6:0] dcnt_a;
    logic [6:0] dcnt_b;
    logic [1:0] per_cnt;
    logic       tflag;
    logic       eflag;
    logic       cap_prev;
    logic [3:0] cap_cnt;
    logic       cmp_pin;
    logic       cap_str;
    logic       trst;
    logic       adc;
    logic [31:0] rdata;
  } epw_state_t;

  epw_state_t s_q;
  epw_state_t s_d;

  logic        acc;
  logic        wr;
  logic        pwm_mode;
  logic [1:0]  cfg_now;
  logic [9:0]  cnt10;
  logic [3:0]  mod_sig;
  logic [3:0]  act_sig;
  logic [3:0]  en_pin;
  logic [3:0]  pol;
  logic [3:0]  pre_pol;
  logic [1:0]  pss [4];
  logic        ase;
  logic        mapped;

  assign acc      = psel & penable;
  assign wr       = acc & pwrite & clk_en;
  assign pready   = acc;
  assign mapped   = (paddr <= EPW_OFF_STATUS) && (paddr[1:0] == 2'b00);
  assign pslverr  = acc & ~mapped;
  assign prdata   = s_q.rdata;
  assign pwm_mode = s_q.mode[3:2] == EPW_PWM_TOP;
  assign cfg_now  = HAS_BRIDGE ? s_q.mode[7:6] : EPW_CFG_SINGLE;
  assign cnt10    = {tmr_count, tmr_prescale};
  assign ase      = s_q.sdc[EPW_ASE_POS];
  assign pol      = {s_q.mode[0], s_q.mode[1], s_q.mode[0], s_q.mode[1]};

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.cap_str = 1'b0;
    s_d.trst    = 1'b0;
    s_d.adc     = 1'b0;
    // ****************************************
    // register writes
    // ****************************************
    if (wr) begin
      case (paddr)
        EPW_OFF_TIMER_SEL: s_d.tsel = pwdata[7:0];
        EPW_OFF_MODE_CTRL: s_d.mode = pwdata[7:0];
        EPW_OFF_SHUTDOWN: begin
          s_d.sdc[6:0] = pwdata[6:0];
          if (!shutdown_in || pwdata[EPW_ASE_POS])
            s_d.sdc[EPW_ASE_POS] = pwdata[EPW_ASE_POS];
        end
        EPW_OFF_STEERING:  s_d.steer = {3'h0, pwdata[4:0]};
        EPW_OFF_DEADBAND:  s_d.dbc   = pwdata[7:0];
        EPW_OFF_DUTY_HIGH: s_d.duty  = pwdata[7:0];
        EPW_OFF_STATUS: begin
          if (pwdata[0])
            s_d.tflag = 1'b0;
          if (pwdata[1])
            s_d.eflag = 1'b0;
        end
        default: ;
      endcase
    end
    if (psel && !penable) begin
      case (paddr)
        EPW_OFF_TIMER_SEL: s_d.rdata = {24'h0, s_q.tsel};
        EPW_OFF_MODE_CTRL: s_d.rdata = {24'h0, s_q.mode};
        EPW_OFF_SHUTDOWN:  s_d.rdata = {24'h0, s_q.sdc};
        EPW_OFF_STEERING:  s_d.rdata = {24'h0, s_q.steer};
        EPW_OFF_DEADBAND:  s_d.rdata = {24'h0, s_q.dbc};
        EPW_OFF_DUTY_HIGH: s_d.rdata = {24'h0, s_q.duty};
        EPW_OFF_STATUS:    s_d.rdata = {28'h0, s_q.cfg_act, s_q.eflag, s_q.tflag};
        default:           s_d.rdata = 32'h0;
      endcase
    end
    // ****************************************
    // shutdown latch and auto-restart
    // ****************************************
    if (shutdown_in)
      s_d.sdc[EPW_ASE_POS] = 1'b1;
    else if (s_q.dbc[EPW_RSEN_POS] && ase && tmr_period_match)
      s_d.sdc[EPW_ASE_POS] = 1'b0;
    // ****************************************
    // steering update
    // ****************************************
    if (!s_d.steer[EPW_SYNC_POS])
      s_d.steer_act = s_d.steer[3:0];
    else if (tmr_period_match)
      s_d.steer_act = s_q.steer[3:0];
    // ****************************************
    // period start: latch duty, track direction
    // ****************************************
    if (tmr_period_match) begin
      s_d.duty_lat = {s_q.duty, s_q.mode[5:4]};
      s_d.pwm_raw  = 1'b1;
      s_d.cfg_act  = cfg_now;
      s_d.dir      = EPW_DIR_RUN;
      if (pwm_mode && s_q.per_cnt != 2'h2)
        s_d.per_cnt = s_q.per_cnt + 2'h1;
      if (pwm_mode && s_q.per_cnt == 2'h1)
        s_d.tflag = 1'b1;
      else if (s_q.per_cnt == 2'h2)
        s_d.tflag = 1'b1;
    end else if (cnt10 >= s_q.duty_lat) begin
      s_d.pwm_raw = 1'b0;
    end
    // ****************************************
    // direction change in full bridge
    // ****************************************
    case (s_q.dir)
      EPW_DIR_RUN:
        if (cfg_now[0] && s_q.cfg_act[0] && cfg_now != s_q.cfg_act)
          s_d.dir = EPW_DIR_TURN;
      EPW_DIR_TURN:
        if (tmr_period - tmr_count <= EPW_DIR_LEAD) begin
          s_d.dir     = EPW_DIR_WAIT;
          s_d.cfg_act = cfg_now;
        end
      EPW_DIR_WAIT: ;
      default: s_d.dir = EPW_DIR_RUN;
    endcase
    // ****************************************
    // dead-band on rising edge, half bridge only
    // ****************************************
    if (!s_q.pwm_raw)
      s_d.dcnt_a = s_q.dbc[6:0];
    else if (s_q.dcnt_a != 7'h0)
      s_d.dcnt_a = s_q.dcnt_a - 7'h1;
    if (s_q.pwm_raw)
      s_d.dcnt_b = s_q.dbc[6:0];
    else if (s_q.dcnt_b != 7'h0)
      s_d.dcnt_b = s_q.dcnt_b - 7'h1;
    s_d.out_a = s_q.pwm_raw
                && (s_q.dcnt_a == 7'h0 || s_q.cfg_act != EPW_CFG_HALF);
    s_d.out_b = !s_q.pwm_raw && (s_q.dcnt_b == 7'h0);
    // ****************************************
    // capture and compare
    // ****************************************
    s_d.cap_prev = capture_pin;
    case (s_q.mode[3:0])
      EPW_MODE_CAP_FALL: s_d.cap_str = s_q.cap_prev && !capture_pin;
      EPW_MODE_CAP_RISE: s_d.cap_str = !s_q.cap_prev && capture_pin;
      EPW_MODE_CAP_R4, EPW_MODE_CAP_R16:
        if (!s_q.cap_prev && capture_pin) begin
          s_d.cap_cnt = s_q.cap_cnt + 4'h1;
          s_d.cap_str = (s_q.cap_cnt & ((s_q.mode[0]) ? EPW_CAP_DIV16 : EPW_CAP_DIV4))
                        == ((s_q.mode[0]) ? EPW_CAP_DIV16 : EPW_CAP_DIV4);
        end
      EPW_MODE_CMP_TGL:
        if (cmp_match)
          s_d.cmp_pin = !s_q.cmp_pin;
      EPW_MODE_CMP_SET:
        if (cmp_match)
          s_d.cmp_pin = 1'b1;
      EPW_MODE_CMP_CLR:
        if (cmp_match)
          s_d.cmp_pin = 1'b0;
      EPW_MODE_CMP_SPEC:
        if (cmp_match) begin
          s_d.trst = 1'b1;
          s_d.adc  = IS_SECOND_MOD;
        end
      default: ;
    endcase
    if (wr && paddr == EPW_OFF_MODE_CTRL) begin
      s_d.cap_cnt = 4'h0;
      if (pwdata[3:0] == EPW_MODE_CMP_SET)
        s_d.cmp_pin = 1'b0;
      if (pwdata[3:0] == EPW_MODE_CMP_CLR)
        s_d.cmp_pin = 1'b1;
    end
    if (s_d.cap_str || (cmp_match && s_q.mode[3] && !s_q.mode[2]))
      s_d.eflag = 1'b1;
    // ****************************************
    // module off
    // ****************************************
    if (s_q.mode[3:0] == EPW_MODE_OFF) begin
      s_d.per_cnt  = 2'h0;
      s_d.cap_cnt  = 4'h0;
      s_d.cmp_pin  = 1'b0;
      s_d.pwm_raw  = 1'b0;
      s_d.out_a    = 1'b0;
      s_d.out_b    = 1'b0;
      s_d.dir      = EPW_DIR_RUN;
    end
  end

  // ****************************************
  // pin mapping
  // ****************************************
  always_comb begin
    mod_sig = 4'h0;
    act_sig = 4'h0;
    en_pin  = 4'h0;
    if (pwm_mode) begin
      case (s_q.cfg_act)
        EPW_CFG_SINGLE: begin
          en_pin  = s_q.steer_act;
          mod_sig = {4{s_q.out_a}};
        end
        EPW_CFG_FWD: begin
          en_pin  = 4'hf;
          mod_sig = {s_q.out_a && s_q.dir != EPW_DIR_WAIT, 3'h0};
          act_sig = 4'h1;
        end
        EPW_CFG_HALF: begin
          en_pin  = 4'h3;
          mod_sig = {2'h0, s_q.out_b, s_q.out_a};
        end
        default: begin
          en_pin  = 4'hf;
          mod_sig = {2'h0, s_q.out_a && s_q.dir != EPW_DIR_WAIT, 1'b0};
          act_sig = 4'h4;
        end
      endcase
    end else if (s_q.mode[3:0] != EPW_MODE_OFF && s_q.mode[3:0] != EPW_MODE_CMP_SW
                 && s_q.mode[3]) begin
      en_pin  = 4'h1;
      mod_sig = {3'h0, s_q.cmp_pin};
    end else if (s_q.mode[3:0] == EPW_MODE_CMP_TGL) begin
      en_pin  = 4'h1;
      mod_sig = {3'h0, s_q.cmp_pin};
    end
    pre_pol = pwm_mode ? ((mod_sig | act_sig) ^ pol) : mod_sig;
  end

  assign pss[0] = s_q.sdc[EPW_PSS_AC_POS +: 2];
  assign pss[1] = s_q.sdc[EPW_PSS_BD_POS +: 2];
  assign pss[2] = s_q.sdc[EPW_PSS_AC_POS +: 2];
  assign pss[3] = s_q.sdc[EPW_PSS_BD_POS +: 2];

  // shutdown overrides only enabled pins
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_owned[i] = en_pin[i];
      if (pwm_mode && ase && en_pin[i]) begin
        pin_out[i] = pss[i] == EPW_PSS_HIGH;
        pin_oe[i]  = !pss[i][1];
      end else begin
        pin_out[i] = pre_pol[i];
        pin_oe[i]  = en_pin[i];
      end
    end
  end

  assign timer_period_flag = s_q.tflag;
  assign module_event_flag = s_q.eflag;
  assign capture_strobe    = s_q.cap_str;
  assign timer_reset       = s_q.trst;
  assign adc_start         = s_q.adc;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q           <= '0;
      s_q.tsel      <= EPW_RST_TIMER_SEL;
      s_q.mode      <= EPW_RST_MODE_CTRL;
      s_q.sdc       <= EPW_RST_SHUTDOWN;
      s_q.steer     <= EPW_RST_STEERING;
      s_q.steer_act <= EPW_RST_STEERING[3:0];
      s_q.dbc       <= EPW_RST_DEADBAND;
      s_q.duty      <= EPW_RST_DUTY_HIGH;
      s_q.dir       <= EPW_DIR_RUN;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

endmodule // epw_output_stage

// ### verification/epw_output_stage_props.sv
/*
  epw_output_stage_props: port assertions for the output stage.
  assumes it is bound to epw_output_stage, one clock, sync reset.
*/
`timescale 1ns/1ps
module epw_output_stage_props (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       srst,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // events
  input wire logic       tmr_period_match,
  input wire logic       cmp_match,
  input wire logic       timer_period_flag,
  input wire logic       timer_reset,
  input wire logic       adc_start,
  input wire logic       capture_strobe,
  // pins
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_owned
);
  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_trst_pulse;
    timer_reset ##1 !timer_reset;
  endsequence
  a_ready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready not tied to access phase");
  a_err_access_only: assert property (pslverr |-> s_access)
    else $error("pslverr outside access phase");
  a_oe_owned_only: assert property ((pin_oe & ~pin_owned) == 4'h0)
    else $error("driven pin not owned");
  a_reset_pins_off: assert property ($fell(srst) |-> pin_oe == 4'h0 && !timer_period_flag)
    else $error("pins or flag active after reset");
  a_tflag_on_period: assert property ($rose(timer_period_flag) |-> $past(tmr_period_match))
    else $error("timer flag set off period start");
  a_trst_on_match: assert property ($rose(timer_reset) |-> $past(cmp_match) ##0 s_trst_pulse)
    else $error("timer reset not a match pulse");
  a_adc_with_trst: assert property (adc_start |-> timer_reset)
    else $error("conversion start without timer reset");
  a_cap_one_pulse: assert property (capture_strobe |=> !capture_strobe)
    else $error("capture strobe longer than one cycle");
endmodule // epw_output_stage_props

bind epw_output_stage epw_output_stage_props epw_output_stage_props_i (
  .clk_sys, .srst, .psel, .penable, .pready, .pslverr, .tmr_period_match,
  .cmp_match, .timer_period_flag, .timer_reset, .adc_start, .capture_strobe,
  .pin_oe, .pin_owned);

// ### verification/epw_drv_model.sv
/*
  epw_drv_model: far-side switch driver inputs seen at the pins.
  assumes a pull-down resistor on every pwm pin.
*/
`timescale 1ns/1ps
module epw_drv_model (
  // pins
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  // resolved levels
  output logic      [3:0] pin_lvl
);
  // released pins fall to the pull-down
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : 1'b0;
    end
  end
endmodule // epw_drv_model

// ### verification/epw_output_stage_tb.sv
/*
  epw_output_stage_tb: self-checking bench for the output stage.
  assumes a time base of 64 counts, four prescale steps per count.
*/
`timescale 1ns/1ps
module epw_output_stage_tb;
  import epw_pkg::*;
  // ********************************
  // stimulus and time base
  // ********************************
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  tmr_count = 8'h00;
  logic [1:0]  tmr_prescale = 2'h0;
  logic        tmr_period_match = 1'b0;
  logic        cmp_match = 1'b0;
  logic        capture_pin = 1'b0;
  logic        shutdown_in = 1'b0;
  logic        pready, pslverr, timer_period_flag, module_event_flag;
  logic        capture_strobe, timer_reset, adc_start;
  logic [31:0] prdata;
  logic [3:0]  pin_out, pin_oe, pin_owned, pin_lvl;
  int          num_errors = 0;
  int          checked = 0;
  int          n_cap = 0;
  int          n_trst = 0;
  int          n_adc = 0;

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tmr_prescale <= tmr_prescale + 2'h1;
    tmr_period_match <= (tmr_prescale == 2'h3) && (tmr_count == 8'h3f);
    if (tmr_prescale == 2'h3) begin
      tmr_count <= (tmr_count == 8'h3f) ? 8'h00 : tmr_count + 8'h01;
    end
    n_cap <= n_cap + int'(capture_strobe === 1'b1);
    n_trst <= n_trst + int'(timer_reset === 1'b1);
    n_adc <= n_adc + int'(adc_start === 1'b1);
  end

  epw_output_stage #(.HAS_BRIDGE(1'b1), .IS_SECOND_MOD(1'b1)) epw_output_stage_i (
    .clk_sys, .srst, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .tmr_count, .tmr_period(8'h3f), .tmr_prescale,
    .tmr_period_match, .cmp_match, .capture_pin, .shutdown_in, .timer_period_flag,
    .module_event_flag, .capture_strobe, .timer_reset, .adc_start, .pin_out,
    .pin_oe, .pin_owned);
  epw_drv_model epw_drv_model_i (.pin_out, .pin_oe, .pin_lvl);

  // ********************************
  // tasks
  // ********************************
  task finish_test;
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [31:0] q, output logic er);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        er;
    apb(1'b1, a, d, q, er);
  endtask

  task at(input logic [7:0] c);
    do @(posedge clk_sys); while (!(tmr_count == c && tmr_prescale == 2'h1));
    #1;
  endtask

  task pulse_cmp;
    @(posedge clk_sys);
    cmp_match <= 1'b1;
    @(posedge clk_sys);
    cmp_match <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task toggle_cap(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk_sys);
      capture_pin <= ~capture_pin;
    end
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task t_regs;
    logic [31:0] q;
    logic        er;
    apb(1'b0, EPW_OFF_STEERING, 8'h00, q, er);
    chk("steer rst", q, {24'h0, EPW_RST_STEERING});
    apb(1'b0, EPW_OFF_MODE_CTRL, 8'h00, q, er);
    chk("mode rst", q, {24'h0, EPW_RST_MODE_CTRL});
    wr(EPW_OFF_DEADBAND, 8'h95);
    apb(1'b0, EPW_OFF_DEADBAND, 8'h00, q, er);
    chk("db rw", q, 32'h95);
    apb(1'b0, 8'h1c, 8'h00, q, er);
    chk("unmapped err", 32'(er), 32'h1);
    chk("unmapped data", q, 32'h0);
  endtask

  task t_steer;
    wr(EPW_OFF_DUTY_HIGH, 8'h20);
    wr(EPW_OFF_STEERING, 8'h0f);
    wr(EPW_OFF_MODE_CTRL, 8'h0c);
    at(8'h00);
    at(8'h04);
    chk("steer act", 32'(pin_lvl), 32'hf);
    chk("tflag first", 32'(timer_period_flag), 32'h0);
    at(8'h30);
    chk("steer idle", 32'(pin_lvl), 32'h0);
    wr(EPW_OFF_MODE_CTRL, 8'h0d);
    at(8'h04);
    chk("steer pol", 32'(pin_lvl), 32'h5);
    chk("tflag second", 32'(timer_period_flag), 32'h1);
    wr(EPW_OFF_STEERING, 8'h01);
    chk("steer now", 32'(pin_owned), 32'h1);
    wr(EPW_OFF_STEERING, 8'h13);
    chk("sync hold", 32'(pin_owned), 32'h1);
    at(8'h02);
    chk("sync done", 32'(pin_owned), 32'h3);
  endtask

  task t_bridge;
    wr(EPW_OFF_MODE_CTRL, 8'h4c);
    at(8'h00);
    at(8'h04);
    chk("fwd act", 32'(pin_lvl), 32'h9);
    wr(EPW_OFF_MODE_CTRL, 8'hcc);
    at(8'h00);
    at(8'h04);
    chk("rev act", 32'(pin_lvl), 32'h6);
    at(8'h30);
    chk("rev idle", 32'(pin_lvl), 32'h4);
    wr(EPW_OFF_MODE_CTRL, 8'h4c);
    at(8'h3a);
    chk("turn early", 32'(pin_lvl), 32'h4);
    at(8'h3c);
    chk("turn lead", 32'(pin_lvl), 32'h1);
  endtask

  task t_half;
    wr(EPW_OFF_DEADBAND, 8'h14);
    wr(EPW_OFF_MODE_CTRL, 8'h8c);
    at(8'h00);
    at(8'h02);
    chk("half dly a", 32'(pin_lvl[1:0]), 32'h0);
    at(8'h0a);
    chk("half on a", 32'(pin_lvl[1:0]), 32'h1);
    at(8'h22);
    chk("half dly b", 32'(pin_lvl[1:0]), 32'h0);
    at(8'h2a);
    chk("half on b", 32'(pin_lvl[1:0]), 32'h2);
    wr(EPW_OFF_DUTY_HIGH, 8'h04);
    wr(EPW_OFF_DEADBAND, 8'h30);
    at(8'h00);
    at(8'h02);
    chk("db over duty", 32'(pin_lvl[0]), 32'h0);
    at(8'h0c);
    chk("db over end", 32'(pin_lvl[0]), 32'h0);
  endtask

  task t_shut;
    wr(EPW_OFF_DUTY_HIGH, 8'h20);
    wr(EPW_OFF_MODE_CTRL, 8'h0c);
    wr(EPW_OFF_STEERING, 8'h03);
    wr(EPW_OFF_SHUTDOWN, 8'h04);
    at(8'h04);
    @(posedge clk_sys);
    shutdown_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("sd level", 32'(pin_lvl[1:0]), 32'h1);
    chk("sd owned", 32'(pin_owned), 32'h3);
    wr(EPW_OFF_SHUTDOWN, 8'h88);
    chk("sd float", 32'(pin_oe[1:0]), 32'h2);
    @(posedge clk_sys);
    shutdown_in <= 1'b0;
    wr(EPW_OFF_SHUTDOWN, 8'h00);
  endtask

  task t_cmp;
    wr(EPW_OFF_MODE_CTRL, {4'h0, EPW_MODE_CMP_SET});
    chk("cmp init", 32'(pin_lvl[0]), 32'h0);
    chk("cmp own", 32'(pin_owned), 32'h1);
    pulse_cmp;
    chk("cmp set", 32'(pin_lvl[0]), 32'h1);
    chk("cmp flag", 32'(module_event_flag), 32'h1);
    wr(EPW_OFF_MODE_CTRL, {4'h0, EPW_MODE_CMP_CLR});
    chk("clr init", 32'(pin_lvl[0]), 32'h1);
    pulse_cmp;
    chk("clr match", 32'(pin_lvl[0]), 32'h0);
    wr(EPW_OFF_MODE_CTRL, {4'h0, EPW_MODE_CMP_TGL});
    pulse_cmp;
    chk("tgl match", 32'(pin_lvl[0]), 32'h1);
    wr(EPW_OFF_MODE_CTRL, {4'h0, EPW_MODE_CMP_SW});
    chk("sw release", 32'(pin_owned), 32'h0);
    wr(EPW_OFF_STATUS, 8'h02);
    chk("flag clear", 32'(module_event_flag), 32'h0);
    pulse_cmp;
    chk("sw flag", 32'(module_event_flag), 32'h1);
    wr(EPW_OFF_MODE_CTRL, {4'h0, EPW_MODE_CMP_SPEC});
    pulse_cmp;
    chk("spec trst", n_trst, 32'h1);
    chk("spec adc", n_adc, 32'h1);
    wr(EPW_OFF_MODE_CTRL, {4'h0, EPW_MODE_OFF});
    chk("off owned", 32'(pin_owned), 32'h0);
    wr(EPW_OFF_MODE_CTRL, {4'h0, EPW_MODE_CAP_R4});
    toggle_cap(8);
    chk("cap div4", n_cap, 32'h1);
    wr(EPW_OFF_MODE_CTRL, {4'h0, EPW_MODE_CAP_FALL});
    toggle_cap(4);
    chk("cap fall", n_cap, 32'h3);
    wr(EPW_OFF_MODE_CTRL, {4'h0, EPW_MODE_CAP_RISE});
    toggle_cap(4);
    chk("cap rise", n_cap, 32'h5);
    wr(EPW_OFF_MODE_CTRL, {4'h0, EPW_MODE_CAP_R16});
    toggle_cap(30);
    chk("cap div16 early", n_cap, 32'h5);
    toggle_cap(2);
    chk("cap div16", n_cap, 32'h6);
  endtask

  // ********************************
  // sequence
  // ********************************
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs;
    t_steer;
    t_bridge;
    t_half;
    t_shut;
    t_cmp;
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    finish_test;
  end
endmodule // epw_output_stage_tb
